// ### hw/ifv_pkg.sv
package ifv_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_VECTOR = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    // flag and enable bit positions
    localparam int BIT_START = 7;
    localparam int BIT_GCALL = 6;
    localparam int BIT_TX = 5;
    localparam int BIT_RX = 4;
    localparam int BIT_ACCESS = 3;
    localparam int BIT_OWN = 2;
    localparam int BIT_NACK = 1;
    localparam int BIT_ARB = 0;
    // control register bits
    localparam int CTL_STOP = 0;
    localparam int CTL_REPEAT = 1;
    // values after reset
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [1:0] CONTROL_RST = 2'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    // vector codes, index is the flag bit
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam logic [15:0] VEC_CODE [8] = '{
        16'h0002, 16'h0004, 16'h0006, 16'h0008,
        16'h000a, 16'h000c, 16'h000e, 16'h0010};
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // register selects
    typedef enum logic [2:0] {
        SEL_FLAGS, SEL_ENABLE, SEL_VECTOR,
        SEL_CONTROL, SEL_COUNT, SEL_NONE
    } ifv_sel_t;
endpackage

// ### hw/ifv_flags_vector.sv
// Behaviour
// - eight rw event flags, bits 7..0, cleared at reset, 1 is pending
// - master tx, stop set, no repeat: access ready at count zero, all sent
// - master tx, repeat: access ready when last byte sent after stop
// - master rx, stop set, no repeat: access ready at count zero while busy, rx empty
// - master rx, repeat: access ready after last byte, rx empty, stop
// - slave tx: access ready on stop; slave rx also needs rx empty
// - read-only vector gives code of highest priority pending flag
// - rw enable bit per flag at same positions, cleared at reset
// - count reads remaining while busy, programmed count otherwise
module ifv_flags_vector #(
    parameter int ADDR_W = 8,
    parameter int COUNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic start_detect_evt,
    input wire logic general_call_evt,
    input wire logic tx_ready_evt,
    input wire logic rx_ready_evt,
    input wire logic own_address_evt,
    input wire logic no_ack_evt,
    input wire logic arb_lost_evt,
    input wire logic master_mode,
    input wire logic transmit_mode,
    input wire logic all_data_sent,
    input wire logic last_byte_sent,
    input wire logic last_byte_received,
    input wire logic stop_received,
    input wire logic rx_buffer_empty,
    input wire logic bus_busy_bit,
    input wire logic byte_done,
    output logic stop_request_bit,
    output logic repeat_mode_bit,
    output logic [COUNT_W-1:0] transfer_byte_count,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // address decode, shared by the read and the write path
    function automatic ifv_pkg::ifv_sel_t ifv_decode(
        input logic [ADDR_W-1:0] a);
        ifv_pkg::ifv_sel_t s;
        s = ifv_pkg::SEL_NONE;
        if (a == ADDR_W'(ifv_pkg::OFS_FLAGS))
            s = ifv_pkg::SEL_FLAGS;
        else if (a == ADDR_W'(ifv_pkg::OFS_ENABLE))
            s = ifv_pkg::SEL_ENABLE;
        else if (a == ADDR_W'(ifv_pkg::OFS_VECTOR))
            s = ifv_pkg::SEL_VECTOR;
        else if (a == ADDR_W'(ifv_pkg::OFS_CONTROL))
            s = ifv_pkg::SEL_CONTROL;
        else if (a == ADDR_W'(ifv_pkg::OFS_COUNT))
            s = ifv_pkg::SEL_COUNT;
        return s;
    endfunction

    // lowest bit wins, so scan from the top down
    function automatic logic [15:0] ifv_vector(input logic [7:0] f);
        logic [15:0] v;
        v = ifv_pkg::VEC_NONE;
        for (int i = 7; i >= 0; i--)
        begin
            if (f[i])
                v = ifv_pkg::VEC_CODE[i];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] flags, next_flags;
    logic [7:0] enable, next_enable;
    logic stop_q, next_stop_q;
    logic repeat_q, next_repeat_q;
    logic [COUNT_W-1:0] prog_count, next_prog_count;
    logic [COUNT_W-1:0] remaining, next_remaining;
    logic rx_wait, next_rx_wait;
    logic mrx_cond_q, next_mrx_cond_q;
    logic irq_q, next_irq_q;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic do_write;
    ifv_pkg::ifv_sel_t wsel, rsel;
    logic [COUNT_W-1:0] reported;
    logic mrx_cond, ardy_set, ardy_wait_fire;
    logic [7:0] events;

    ////////////////////////////////////////////////////////////////////
    // bus handshakes

    // one write in flight: hold the response until bready
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign do_write = aw_held && w_held;
    assign wsel = ifv_decode(aw_addr);
    assign rsel = ifv_decode(s_axi_araddr);
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign stop_request_bit = stop_q;
    assign repeat_mode_bit = repeat_q;
    assign transfer_byte_count = prog_count;
    assign irq = irq_q;

    // remaining count only means something during a transfer
    assign reported = bus_busy_bit ? remaining : prog_count;

    ////////////////////////////////////////////////////////////////////
    // access ready conditions

    // master rx without repeat is a level, so only its rise sets
    assign mrx_cond = master_mode && !transmit_mode && stop_q &&
        !repeat_q && bus_busy_bit && remaining == '0 &&
        rx_buffer_empty;
    assign ardy_wait_fire = rx_wait && rx_buffer_empty;
    assign ardy_set =
        (master_mode && transmit_mode && stop_q && !repeat_q &&
         remaining == '0 && all_data_sent) ||
        (master_mode && transmit_mode && repeat_q && stop_q &&
         last_byte_sent) ||
        (mrx_cond && !mrx_cond_q) ||
        (!master_mode && transmit_mode && stop_received) ||
        ardy_wait_fire;

    // event vector in flag bit order
    always_comb
    begin
        events = 8'h00;
        events[ifv_pkg::BIT_START] = start_detect_evt;
        events[ifv_pkg::BIT_GCALL] = general_call_evt;
        events[ifv_pkg::BIT_TX] = tx_ready_evt;
        events[ifv_pkg::BIT_RX] = rx_ready_evt;
        events[ifv_pkg::BIT_ACCESS] = ardy_set;
        events[ifv_pkg::BIT_OWN] = own_address_evt;
        events[ifv_pkg::BIT_NACK] = no_ack_evt;
        events[ifv_pkg::BIT_ARB] = arb_lost_evt;
    end

    ////////////////////////////////////////////////////////////////////
    // next values for registers, bus and tracking

    always_comb
    begin
        next_flags = flags;
        next_enable = enable;
        next_stop_q = stop_q;
        next_repeat_q = repeat_q;
        next_prog_count = prog_count;
        next_remaining = remaining;
        next_rx_wait = rx_wait;
        next_mrx_cond_q = mrx_cond;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        // channels are taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        // all registers live in byte lane 0
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ifv_pkg::RESP_OKAY;
            if (wsel == ifv_pkg::SEL_NONE)
                next_bresp = ifv_pkg::RESP_SLVERR;
            else if (w_lane0 && wsel == ifv_pkg::SEL_FLAGS)
                next_flags = w_data[7:0];
            else if (w_lane0 && wsel == ifv_pkg::SEL_ENABLE)
                next_enable = w_data[7:0];
            else if (w_lane0 && wsel == ifv_pkg::SEL_CONTROL)
            begin
                next_stop_q = w_data[ifv_pkg::CTL_STOP];
                next_repeat_q = w_data[ifv_pkg::CTL_REPEAT];
            end
            else if (w_lane0 && wsel == ifv_pkg::SEL_COUNT)
                next_prog_count = w_data[COUNT_W-1:0];
        end
        // hardware set wins over a software clear
        next_flags = next_flags | events;
        // wait for rx empty after the closing byte or stop
        if (ardy_wait_fire)
            next_rx_wait = 1'b0;
        if ((master_mode && !transmit_mode && repeat_q && stop_q &&
             last_byte_received) ||
            (!master_mode && !transmit_mode && stop_received))
            next_rx_wait = 1'b1;
        // count follows the programmed value when idle
        if (!bus_busy_bit)
            next_remaining = next_prog_count;
        else if (do_write && w_lane0 && wsel == ifv_pkg::SEL_COUNT)
            next_remaining = next_prog_count;
        else if (byte_done && remaining != '0)
            next_remaining = remaining - COUNT_W'(1);
        // read answers one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = ifv_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (rsel == ifv_pkg::SEL_FLAGS)
                next_rdata[7:0] = flags;
            else if (rsel == ifv_pkg::SEL_ENABLE)
                next_rdata[7:0] = enable;
            else if (rsel == ifv_pkg::SEL_VECTOR)
                next_rdata[15:0] = ifv_vector(flags);
            else if (rsel == ifv_pkg::SEL_CONTROL)
            begin
                next_rdata[ifv_pkg::CTL_STOP] = stop_q;
                next_rdata[ifv_pkg::CTL_REPEAT] = repeat_q;
            end
            else if (rsel == ifv_pkg::SEL_COUNT)
                next_rdata[COUNT_W-1:0] = reported;
            else
                next_rresp = ifv_pkg::RESP_SLVERR;
        end
        // request follows the flags as they are registered
        next_irq_q = |(next_flags & next_enable);
    end

    // register everything; reset gives constants only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags <= ifv_pkg::FLAGS_RST;
            enable <= ifv_pkg::ENABLE_RST;
            stop_q <= ifv_pkg::CONTROL_RST[ifv_pkg::CTL_STOP];
            repeat_q <= ifv_pkg::CONTROL_RST[ifv_pkg::CTL_REPEAT];
            prog_count <= COUNT_W'(ifv_pkg::COUNT_RST);
            remaining <= COUNT_W'(ifv_pkg::COUNT_RST);
            rx_wait <= 1'b0;
            mrx_cond_q <= 1'b0;
            irq_q <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= ifv_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ifv_pkg::RESP_OKAY;
        end
        else
        begin
            flags <= next_flags;
            enable <= next_enable;
            stop_q <= next_stop_q;
            repeat_q <= next_repeat_q;
            prog_count <= next_prog_count;
            remaining <= next_remaining;
            rx_wait <= next_rx_wait;
            mrx_cond_q <= next_mrx_cond_q;
            irq_q <= next_irq_q;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_mtx_done;
        master_mode && transmit_mode && stop_q && !repeat_q &&
        remaining == '0 && all_data_sent;
    endsequence

    sequence s_rx_closing;
        !master_mode && !transmit_mode && stop_received &&
        rx_buffer_empty;
    endsequence

    a_flags_reset_clear:
    assert property (disable iff (1'b0)
        !aresetn |=> flags == 8'h00 && enable == 8'h00)
        else $error("flags or enables not cleared by reset");

    a_arb_event_sets:
    assert property (arb_lost_evt |=> flags[ifv_pkg::BIT_ARB])
        else $error("arbitration lost event did not set flag");

    a_mtx_stop_ready:
    assert property (s_mtx_done |=> flags[ifv_pkg::BIT_ACCESS])
        else $error("master tx completion missed access ready");

    a_mtx_repeat_ready:
    assert property (master_mode && transmit_mode && repeat_q &&
        stop_q && last_byte_sent |=> flags[ifv_pkg::BIT_ACCESS])
        else $error("repeat tx last byte missed access ready");

    a_mrx_count_ready:
    assert property ($rose(mrx_cond) |-> ##1
        flags[ifv_pkg::BIT_ACCESS])
        else $error("master rx count zero missed access ready");

    a_slave_rx_ready:
    assert property (s_rx_closing ##1 rx_buffer_empty |=>
        flags[ifv_pkg::BIT_ACCESS])
        else $error("slave rx stop missed access ready");

    a_vector_top_code:
    assert property (flags[ifv_pkg::BIT_ARB] && s_axi_arvalid &&
        s_axi_arready && s_axi_araddr == ADDR_W'(ifv_pkg::OFS_VECTOR)
        |=> rdata == 32'h0000_0002)
        else $error("vector does not show arbitration lost");

    a_irq_follows:
    assert property (((flags & enable) != 8'h00) == irq)
        else $error("interrupt request does not match flags");

    a_count_steps:
    assert property (bus_busy_bit && byte_done && remaining != '0 &&
        !do_write ##1 bus_busy_bit |-> remaining ==
        $past(remaining) - COUNT_W'(1))
        else $error("remaining count did not step down");

endmodule

// ### tb/ifv_cpu_model.sv
// processor side of the register bus: one write and one read at a time
module ifv_cpu_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle at time zero; full word strobes, the block uses one lane
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
        wstrb = 4'hf;
    end

    ////////////////////////////////////////////////////////////////////////
    // each channel is dropped at its own handshake, never earlier
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
            end
        end while (!bvalid && n < 64);
        if (!bvalid)
            hung = 1'b1;
    endtask

    // rready stays up until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        {d, r} = '1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end while (!rvalid && n < 64);
        if (!rvalid)
            hung = 1'b1;
    endtask
endmodule

// ### tb/test_i2c_interrupt_flags_vector.sv
module test_i2c_interrupt_flags_vector;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr, transfer_byte_count;
    logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] evt = 8'h00;
    logic [4:0] pl = 5'h00;
    logic master_mode = 1'b0;
    logic transmit_mode = 1'b0;
    logic rx_buffer_empty = 1'b0;
    logic bus_busy_bit = 1'b0;
    logic stop_request_bit, repeat_mode_bit;
    int miscompares = 0;
    int comparisons = 0;

    initial
    begin
        forever #4 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    ifv_flags_vector ifv_flags_vector_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .start_detect_evt(evt[7]),
        .general_call_evt(evt[6]), .tx_ready_evt(evt[5]),
        .rx_ready_evt(evt[4]), .own_address_evt(evt[2]),
        .no_ack_evt(evt[1]), .arb_lost_evt(evt[0]),
        .master_mode(master_mode), .transmit_mode(transmit_mode),
        .all_data_sent(pl[0]), .last_byte_sent(pl[1]),
        .last_byte_received(pl[2]), .stop_received(pl[3]),
        .rx_buffer_empty(rx_buffer_empty), .bus_busy_bit(bus_busy_bit),
        .byte_done(pl[4]), .stop_request_bit(stop_request_bit),
        .repeat_mode_bit(repeat_mode_bit),
        .transfer_byte_count(transfer_byte_count), .irq(irq));

    ifv_cpu_model ifv_cpu_model_i (.aclk(aclk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hung(hung));

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a bus wait that ran out ends the run as a failure
    task automatic guard;
        if (hung)
        begin
            miscompares++;
            tally_and_finish;
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = ifv_pkg::RESP_OKAY);
        logic [1:0] r;
        ifv_cpu_model_i.wr(a, d, r);
        guard;
        cmp({30'h0, r}, {30'h0, er});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = ifv_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        ifv_cpu_model_i.rd(a, d, r);
        guard;
        cmp(d, e);
        cmp({30'h0, r}, {30'h0, er});
    endtask

    // strobes last exactly one cycle; a held level would re-set flags
    task automatic pulse(input logic [7:0] e, input logic [4:0] p);
        @(posedge aclk);
        evt <= e;
        pl <= p;
        @(posedge aclk);
        evt <= 8'h00;
        pl <= 5'h00;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic check_reset;
        rchk(ifv_pkg::OFS_FLAGS, 32'h0);
        rchk(ifv_pkg::OFS_ENABLE, 32'h0);
        rchk(ifv_pkg::OFS_VECTOR, 32'h0);
        rchk(ifv_pkg::OFS_COUNT, 32'h0);
        rchk(8'h14, 32'h0, ifv_pkg::RESP_SLVERR);
        wreg(8'h14, 32'hff, ifv_pkg::RESP_SLVERR);
        // a write without byte lane 0 is answered but must change nothing
        ifv_cpu_model_i.wstrb <= 4'he;
        wreg(ifv_pkg::OFS_ENABLE, 32'hff);
        ifv_cpu_model_i.wstrb <= 4'hf;
        rchk(ifv_pkg::OFS_ENABLE, 32'h0);
        cmp({31'h0, irq}, 32'h0);
    endtask

    // lowest set bit wins, whatever is pending above it
    task automatic check_vector;
        for (int i = 0; i < 8; i++)
        begin
            wreg(ifv_pkg::OFS_FLAGS, 32'hff & (32'hff << i));
            rchk(ifv_pkg::OFS_FLAGS, 32'hff & (32'hff << i));
            rchk(ifv_pkg::OFS_VECTOR, 32'(2 * (i + 1)));
        end
        wreg(ifv_pkg::OFS_VECTOR, 32'h0);
        rchk(ifv_pkg::OFS_VECTOR, 32'h10);
        wreg(ifv_pkg::OFS_FLAGS, 32'h0);
        rchk(ifv_pkg::OFS_VECTOR, 32'h0);
    endtask

    // flags pend silently until their enable bit is set
    task automatic check_events;
        for (int i = 0; i < 8; i++)
        begin
            if (i == ifv_pkg::BIT_ACCESS)
                continue;
            wreg(ifv_pkg::OFS_FLAGS, 32'h0);
            pulse(8'(1 << i), 5'h00);
            rchk(ifv_pkg::OFS_FLAGS, 32'(1 << i));
            cmp({31'h0, irq}, 32'h0);
        end
        wreg(ifv_pkg::OFS_ENABLE, 32'h80);
        rchk(ifv_pkg::OFS_ENABLE, 32'h80);
        repeat (2) @(posedge aclk);
        cmp({31'h0, irq}, 32'h1);
        wreg(ifv_pkg::OFS_FLAGS, 32'h0);
        repeat (2) @(posedge aclk);
        cmp({31'h0, irq}, 32'h0);
    endtask

    // levels go neutral first so every set comes from this case alone
    task automatic ar_case(input logic m, t, input logic [1:0] ctl,
        input logic [7:0] cnt, input logic busy, rxe,
        input logic [4:0] p, input logic [7:0] exp);
        @(posedge aclk);
        {master_mode, transmit_mode, bus_busy_bit, rx_buffer_empty} <= '0;
        wreg(ifv_pkg::OFS_COUNT, 32'(cnt));
        wreg(ifv_pkg::OFS_CONTROL, 32'(ctl));
        cmp({30'h0, repeat_mode_bit, stop_request_bit}, 32'(ctl));
        wreg(ifv_pkg::OFS_FLAGS, 32'h0);
        @(posedge aclk);
        {master_mode, transmit_mode, bus_busy_bit, rx_buffer_empty} <=
            {m, t, busy, rxe};
        pulse(8'h00, p);
        // the empty-buffer wait takes two cycles to reach the flag
        repeat (3) @(posedge aclk);
        rchk(ifv_pkg::OFS_FLAGS, 32'(exp));
    endtask

    // remaining count falls while busy and stops at zero
    task automatic check_count;
        wreg(ifv_pkg::OFS_COUNT, 32'h2);
        cmp(32'(transfer_byte_count), 32'h2);
        @(posedge aclk);
        bus_busy_bit <= 1'b1;
        pulse(8'h00, 5'h10);
        rchk(ifv_pkg::OFS_COUNT, 32'h1);
        pulse(8'h00, 5'h10);
        pulse(8'h00, 5'h10);
        rchk(ifv_pkg::OFS_COUNT, 32'h0);
        @(posedge aclk);
        bus_busy_bit <= 1'b0;
        rchk(ifv_pkg::OFS_COUNT, 32'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check_reset;
        check_vector;
        check_events;
        ar_case(1'h1, 1'h1, 2'h1, 8'h00, 1'h0, 1'h0, 5'h01, 8'h08);
        ar_case(1'h1, 1'h1, 2'h1, 8'h03, 1'h0, 1'h0, 5'h01, 8'h00);
        ar_case(1'h1, 1'h1, 2'h3, 8'h03, 1'h0, 1'h0, 5'h02, 8'h08);
        ar_case(1'h1, 1'h1, 2'h2, 8'h03, 1'h0, 1'h0, 5'h02, 8'h00);
        ar_case(1'h1, 1'h0, 2'h1, 8'h00, 1'h1, 1'h1, 5'h00, 8'h08);
        ar_case(1'h1, 1'h0, 2'h1, 8'h00, 1'h1, 1'h0, 5'h00, 8'h00);
        ar_case(1'h1, 1'h0, 2'h3, 8'h02, 1'h0, 1'h1, 5'h04, 8'h08);
        ar_case(1'h0, 1'h1, 2'h0, 8'h00, 1'h0, 1'h0, 5'h08, 8'h08);
        ar_case(1'h0, 1'h0, 2'h0, 8'h00, 1'h0, 1'h1, 5'h08, 8'h08);
        ar_case(1'h0, 1'h0, 2'h0, 8'h00, 1'h0, 1'h0, 5'h08, 8'h00);
        @(posedge aclk);
        rx_buffer_empty <= 1'b1;
        repeat (3) @(posedge aclk);
        rchk(ifv_pkg::OFS_FLAGS, 32'h08);
        check_count;
        tally_and_finish;
    end
endmodule
